/* pci_cfg_pkg.sv */
// Constants, field positions and helpers for the configuration register bank
`default_nettype none

package pci_cfg_pkg;

  // ****************************************************************
  // Configuration byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_VENDOR_IDENT = 8'h00;
  localparam logic [7:0] OFS_DEVICE_IDENT = 8'h02;
  localparam logic [7:0] OFS_COMMAND_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BUS_STATUS_FLAGS = 8'h06;
  localparam logic [7:0] OFS_SILICON_REVISION = 8'h08;
  localparam logic [7:0] OFS_PROGRAMMING_INTERFACE = 8'h09;
  localparam logic [7:0] OFS_SUBCLASS_CODE = 8'h0a;
  localparam logic [7:0] OFS_CLASS_CODE = 8'h0b;
  localparam logic [7:0] OFS_HEADER_LAYOUT = 8'h0e;
  localparam logic [7:0] OFS_MEMORY_WINDOW_ADDRESS = 8'h10;
  localparam logic [7:0] OFS_EXPANSION_ROM_ADDRESS = 8'h30;

  // ****************************************************************
  // Fixed contents
  // ****************************************************************
  localparam logic [7:0] CLASS_CODE_VALUE = 8'h03;
  localparam logic [7:0] SUBCLASS_CODE_VALUE = 8'h00;
  localparam logic [7:0] PROGRAMMING_INTERFACE_VALUE = 8'h00;
  localparam logic [7:0] HEADER_LAYOUT_VALUE = 8'h00;

  // ****************************************************************
  // Command field positions, masks and reset value
  // ****************************************************************
  localparam int CMD_IO_ENABLE = 0;
  localparam int CMD_MEM_ENABLE = 1;
  localparam int CMD_PALETTE_SNOOP = 5;
  localparam int CMD_PARITY_RESPONSE = 6;
  localparam int CMD_WAIT_CYCLE = 7;
  localparam int CMD_SERR_ENABLE = 8;
  localparam logic [15:0] CMD_WRITABLE_MASK = 16'h0163;
  localparam logic [15:0] CMD_FIXED_ONES = 16'h0080;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // ****************************************************************
  // Status field positions and fixed pattern
  // ****************************************************************
  localparam int STAT_DETECTED_PARITY = 15;
  localparam int STAT_SIGNALED_SYSERR = 14;
  localparam int STAT_SIGNALED_TABORT = 11;
  localparam logic [15:0] STAT_FIXED_ONES = 16'h0280;
  localparam logic [2:0] STAT_FLAGS_RESET = 3'h0;

  // ****************************************************************
  // Base address registers
  // ****************************************************************
  localparam logic [31:0] MEM_WINDOW_WRITABLE_MASK = 32'hff00_0000;
  localparam logic [31:0] ROM_WRITABLE_MASK = 32'hfffc_0001;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam int ROM_DECODE_ENABLE = 0;

  // Adjacent active byte enables only; none active counts as adjacent
  function automatic logic lanes_adjacent(input logic [3:0] be);
    logic ok;
    ok = 1'b1;
    unique case (be)
      4'h5, 4'h9, 4'ha, 4'hb, 4'hd: ok = 1'b0;
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : lanes_adjacent

endpackage : pci_cfg_pkg

`default_nettype wire

/* byte_lane_merge.sv */
// Byte-lane write merge with a per-bit writable mask
`default_nettype none

module byte_lane_merge #(
  parameter int BYTES = 4,
  parameter logic [8*BYTES-1:0] WRITABLE = '0
) (
  input wire logic [8*BYTES-1:0] old_value, // Current contents
  input wire logic [8*BYTES-1:0] write_data, // Data from the write
  input wire logic [BYTES-1:0] byte_en, // Active-high lane enables
  output logic [8*BYTES-1:0] next_value // Merged result
);

  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (byte_en[i] && WRITABLE[8*i+b]) begin
          next_value[8*i+b] = write_data[8*i+b];
        end else begin
          next_value[8*i+b] = old_value[8*i+b];
        end
      end
    end
  end

endmodule : byte_lane_merge

`default_nettype wire

/* pci_target_config_space.sv */
// Configuration header register bank of a target-only display controller
`default_nettype none

// Behaviour
// [RULE1] Offset 00h returns fixed vendor code, read-only
// [RULE2] Offset 02h returns fixed device code, read-only
// [RULE3] Registers reached only by configuration cycles
// [RULE4] Command bits 15-9 always read zero
// [RULE5] System-error enable resets 0, gates error signalling
// [RULE6] Command bit 7 always reads one
// [RULE7] Parity response resets 0, enables parity-error signal
// [RULE8] Address parity: system error needs bits 6,8
// [RULE9] Palette snoop set: skip palette reads only
// [RULE10] Command bits 4-2 read zero; ignore special cycles
// [RULE11] Memory enable resets 0, gates frame-buffer decode
// [RULE12] I/O enable resets 0, gates port decode
// [RULE13] Host uses only adjacent byte enables
// [RULE14] Status: write one clears, zero keeps
// [RULE15] Any parity error sets status bit 15
// [RULE16] Status 14 records asserted system error
// [RULE17] Status bits 13 and 12 read zero
// [RULE18] Non-adjacent I/O enables: target abort, bit 11
// [RULE19] Status bits 10-9 read binary 01
// [RULE20] Status bit 7 always reads one
// [RULE21] Base class code reads 03h
// [RULE22] Memory base: bits 31-24 writable only
// [RULE23] Reserved offsets read zero, ignore writes
// [RULE24] Writes touch only enabled byte lanes

module pci_target_config_space #(
  parameter logic [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value
) (
  input wire logic clock, // Bus clock
  input wire logic resetn, // Bus reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic cfg_read, // Configuration read request
  input wire logic cfg_write, // Configuration write request
  input wire logic [5:0] cfg_dword, // Dword index, byte offset bits 7-2
  input wire logic [3:0] cfg_byte_en, // Active-high byte enables
  input wire logic [31:0] cfg_wdata, // Write data
  input wire logic addr_parity_err, // Address parity error seen, pulse
  input wire logic data_parity_err, // Data parity error seen, pulse
  input wire logic io_access, // Claimed-range I/O cycle, pulse
  input wire logic [3:0] io_byte_en, // Active-high byte enables of it
  output logic [31:0] cfg_rdata, // Read data
  output logic cfg_done, // Request completed, pulse
  output logic perr_pulse, // Request to drive parity-error line
  output logic serr_pulse, // Request to drive system-error line
  output logic io_target_abort, // Request to end I/O cycle with abort
  output logic io_decode_en, // I/O port decoding enabled
  output logic mem_decode_en, // Frame-buffer memory decoding enabled
  output logic palette_read_claim, // Palette reads are claimed
  output logic rom_decode_en, // Expansion ROM decoding enabled
  output logic [7:0] mem_window_base, // Memory window address bits 31-24
  output logic [13:0] rom_base // ROM address bits 31-18
);

  // ****************************************************************
  // Request decode
  // ****************************************************************
  localparam logic [5:0] IDX_IDENT = pci_cfg_pkg::OFS_VENDOR_IDENT[7:2];
  localparam logic [5:0] IDX_CMD_STAT = pci_cfg_pkg::OFS_COMMAND_CONTROL[7:2];
  localparam logic [5:0] IDX_CLASS = pci_cfg_pkg::OFS_SILICON_REVISION[7:2];
  localparam logic [5:0] IDX_HEADER = pci_cfg_pkg::OFS_HEADER_LAYOUT[7:2];
  localparam logic [5:0] IDX_MEM = pci_cfg_pkg::OFS_MEMORY_WINDOW_ADDRESS[7:2];
  localparam logic [5:0] IDX_ROM = pci_cfg_pkg::OFS_EXPANSION_ROM_ADDRESS[7:2];

  logic [15:0] command_control;
  logic [2:0] status_flags;
  logic [31:0] memory_window_address;
  logic [31:0] expansion_rom_address;
  logic [15:0] next_command;
  logic [31:0] next_mem;
  logic [31:0] next_rom;
  logic [15:0] status_value;
  logic [31:0] read_value;
  logic wr_cmd_stat;
  logic wr_mem;
  logic wr_rom;
  logic abort_event;
  logic syserr_event;
  logic parity_event;
  logic [2:0] clear_flags;

  // Only configuration requests reach the bank
  assign wr_cmd_stat = cfg_write && cfg_dword == IDX_CMD_STAT; // RULE3
  assign wr_mem = cfg_write && cfg_dword == IDX_MEM;
  assign wr_rom = cfg_write && cfg_dword == IDX_ROM;

  // ****************************************************************
  // Write merge
  // ****************************************************************
  byte_lane_merge #(
    .BYTES(2),
    .WRITABLE(pci_cfg_pkg::CMD_WRITABLE_MASK)
  ) merge_command (
    .old_value(command_control),
    .write_data(cfg_wdata[15:0]),
    .byte_en(wr_cmd_stat ? cfg_byte_en[1:0] : 2'h0), // RULE24
    .next_value(next_command)
  );

  byte_lane_merge #(
    .BYTES(4),
    .WRITABLE(pci_cfg_pkg::MEM_WINDOW_WRITABLE_MASK)
  ) merge_mem (
    .old_value(memory_window_address),
    .write_data(cfg_wdata),
    .byte_en(wr_mem ? cfg_byte_en : 4'h0), // RULE22 RULE24
    .next_value(next_mem)
  );

  byte_lane_merge #(
    .BYTES(4),
    .WRITABLE(pci_cfg_pkg::ROM_WRITABLE_MASK)
  ) merge_rom (
    .old_value(expansion_rom_address),
    .write_data(cfg_wdata),
    .byte_en(wr_rom ? cfg_byte_en : 4'h0), // RULE24
    .next_value(next_rom)
  );

  // ****************************************************************
  // Command register and the enables it drives
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      command_control <= pci_cfg_pkg::CMD_RESET; // RULE5 RULE7 RULE11 RULE12
    end else if (ce) begin
      command_control <= next_command;
    end
  end

  // Kept as separate flops so every output comes straight from a register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      io_decode_en <= 1'b0;
      mem_decode_en <= 1'b0;
      palette_read_claim <= 1'b1;
      rom_decode_en <= 1'b0;
      mem_window_base <= 8'h00;
      rom_base <= 14'h0000;
    end else if (ce) begin
      io_decode_en <= next_command[pci_cfg_pkg::CMD_IO_ENABLE]; // RULE12
      mem_decode_en <= next_command[pci_cfg_pkg::CMD_MEM_ENABLE]; // RULE11
      palette_read_claim <= !next_command[pci_cfg_pkg::CMD_PALETTE_SNOOP]; // RULE9
      // ROM needs the memory enable as well as its own decode bit
      rom_decode_en <= next_rom[pci_cfg_pkg::ROM_DECODE_ENABLE]
        && next_command[pci_cfg_pkg::CMD_MEM_ENABLE];
      mem_window_base <= next_mem[31:24];
      rom_base <= next_rom[31:18];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      memory_window_address <= pci_cfg_pkg::BASE_RESET;
      expansion_rom_address <= pci_cfg_pkg::BASE_RESET;
    end else if (ce) begin
      memory_window_address <= next_mem;
      expansion_rom_address <= next_rom;
    end
  end

  // ****************************************************************
  // Error events and status flags
  // ****************************************************************
  assign parity_event = addr_parity_err || data_parity_err;
  assign syserr_event = addr_parity_err && command_control[pci_cfg_pkg::CMD_PARITY_RESPONSE]
    && command_control[pci_cfg_pkg::CMD_SERR_ENABLE]; // RULE5 RULE8
  // Special cycles never reach here, so nothing to decode for them
  assign abort_event = io_access && io_decode_en
    && !pci_cfg_pkg::lanes_adjacent(io_byte_en); // RULE18

  // Flags: bit 2 detected parity, bit 1 system error, bit 0 target abort
  always_comb begin
    clear_flags = 3'h0;
    if (wr_cmd_stat && cfg_byte_en[3]) begin
      clear_flags[2] = cfg_wdata[31]; // RULE14
      clear_flags[1] = cfg_wdata[30];
      clear_flags[0] = cfg_wdata[27];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_flags <= pci_cfg_pkg::STAT_FLAGS_RESET;
    end else if (ce) begin
      // A new event beats a clear in the same cycle
      status_flags[2] <= parity_event || (status_flags[2] && !clear_flags[2]); // RULE15 RULE14
      status_flags[1] <= syserr_event || (status_flags[1] && !clear_flags[1]); // RULE16 RULE8
      status_flags[0] <= abort_event || (status_flags[0] && !clear_flags[0]); // RULE18 RULE14
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      perr_pulse <= 1'b0;
      serr_pulse <= 1'b0;
      io_target_abort <= 1'b0;
    end else if (ce) begin
      perr_pulse <= parity_event
        && command_control[pci_cfg_pkg::CMD_PARITY_RESPONSE]; // RULE7
      serr_pulse <= syserr_event; // RULE8
      io_target_abort <= abort_event; // RULE18
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    status_value = pci_cfg_pkg::STAT_FIXED_ONES; // RULE17 RULE19 RULE20
    status_value[pci_cfg_pkg::STAT_DETECTED_PARITY] = status_flags[2];
    status_value[pci_cfg_pkg::STAT_SIGNALED_SYSERR] = status_flags[1];
    status_value[pci_cfg_pkg::STAT_SIGNALED_TABORT] = status_flags[0];
  end

  always_comb begin
    unique case (cfg_dword)
      IDX_IDENT: read_value = {DEVICE_CODE, VENDOR_CODE}; // RULE1 RULE2
      IDX_CMD_STAT: read_value = {status_value,
        command_control | pci_cfg_pkg::CMD_FIXED_ONES}; // RULE4 RULE6 RULE10
      IDX_CLASS: read_value = {pci_cfg_pkg::CLASS_CODE_VALUE, pci_cfg_pkg::SUBCLASS_CODE_VALUE,
        pci_cfg_pkg::PROGRAMMING_INTERFACE_VALUE, REVISION_CODE}; // RULE21
      IDX_HEADER: read_value = {8'h00, pci_cfg_pkg::HEADER_LAYOUT_VALUE, 16'h0000}; // RULE23
      IDX_MEM: read_value = memory_window_address; // RULE22
      IDX_ROM: read_value = expansion_rom_address;
      default: read_value = 32'h0000_0000; // RULE23
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_done <= 1'b0;
    end else if (ce) begin
      cfg_done <= cfg_read || cfg_write;
      if (cfg_read) begin
        cfg_rdata <= read_value; // RULE3
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_IDENT_FIXED: assert property ((cfg_read && ce && cfg_dword == IDX_IDENT) |=> // RULE1
    (cfg_rdata == {DEVICE_CODE, VENDOR_CODE}
      && cfg_done))
    else $error("identity dword read wrong");

  AST_CMD_FIXED_BITS: assert property ((cfg_read && ce && cfg_dword == IDX_CMD_STAT) |=> // RULE4
    (cfg_rdata[15:9] == 7'h00
      && cfg_rdata[7]
      && cfg_rdata[4:2] == 3'h0))
    else $error("command fixed bits wrong");

  AST_STAT_FIXED_BITS: assert property ((cfg_read && ce && cfg_dword == IDX_CMD_STAT) |=> // RULE19
    (cfg_rdata[29:28] == 2'h0
      && cfg_rdata[26:25] == 2'b01
      && cfg_rdata[23]
      && cfg_rdata[20:16] == 5'h00))
    else $error("status fixed bits wrong");

  AST_SERR_GATED: assert property ((ce && addr_parity_err) |=> // RULE8
    (serr_pulse == ($past(command_control[6])
      && $past(command_control[8]))))
    else $error("system error gating wrong");

  AST_PERR_GATED: assert property ((ce && data_parity_err) |=> // RULE7
    (perr_pulse == $past(command_control[6])))
    else $error("parity error gating wrong");

  AST_PARITY_STICKY: assert property ((ce && parity_event) |=> status_flags[2] [*1] ##1 // RULE15
    (status_flags[2]
      || $past(clear_flags[2])))
    else $error("detected parity flag not set");

  AST_W1C_CLEARS: assert property ((ce && wr_cmd_stat && cfg_byte_en[3] && cfg_wdata[27] && !abort_event) |=> // RULE14
    !status_flags[0])
    else $error("target abort flag not cleared");

  AST_NO_SET_BY_WRITE: assert property ((ce && !abort_event && !status_flags[0]) |=> // RULE14
    !status_flags[0])
    else $error("target abort flag set without event");

  AST_ABORT: assert property ((ce && io_access && io_decode_en && io_byte_en == 4'h5) |=> // RULE18
    (io_target_abort
      && status_flags[0]))
    else $error("non-adjacent I/O did not abort");

  AST_MEM_WINDOW: assert property ((ce && wr_mem && cfg_byte_en[3]) |=> // RULE22
    (memory_window_address == {$past(cfg_wdata[31:24]), 24'h000000}))
    else $error("memory window write wrong");

  AST_RESERVED_ZERO: assert property ((cfg_read && ce && cfg_dword == 6'h05) |=> // RULE23
    cfg_rdata == 32'h0000_0000)
    else $error("reserved offset not zero");

  AST_PALETTE: assert property ((ce && wr_cmd_stat && cfg_byte_en[0]) |=> // RULE9
    (palette_read_claim == !$past(cfg_wdata[5]))
      ##1 (command_control[5] != palette_read_claim || !ce))
    else $error("palette claim wrong");

  AST_SERR_OFF: assert property ((ce && !command_control[8]) |=> // RULE5
    !serr_pulse)
    else $error("system error while disabled");

  AST_SYSERR_FLAG: assert property ((ce && syserr_event) |=> // RULE16
    status_flags[1])
    else $error("system error flag not set");

  AST_NO_SERR_FLAG: assert property ((ce && !syserr_event && !status_flags[1]) |=> // RULE14
    !status_flags[1])
    else $error("system error flag set alone");

  AST_IO_OFF: assert property ((ce && !command_control[0]) |=> // RULE12
    !io_target_abort)
    else $error("abort while I/O disabled");

  AST_ROM_GATED: assert property (rom_decode_en |-> // RULE11
    mem_decode_en)
    else $error("ROM decode without memory enable");

  AST_CLASS_CODE: assert property ((cfg_read && ce && cfg_dword == IDX_CLASS) |=> // RULE21
    cfg_rdata[31:24] == 8'h03)
    else $error("class code wrong");

  COV_CFG_READ: cover property (ce && cfg_read ##1 cfg_done);
  COV_SERR: cover property (serr_pulse);
  COV_ABORT: cover property (io_target_abort);
  COV_W1C: cover property (status_flags[2] ##1 !status_flags[2]);
  COV_SNOOP: cover property (!palette_read_claim);

endmodule : pci_target_config_space

`default_nettype wire

/* host_bridge_model.sv */
// Host bridge model issuing configuration cycles and bus event pulses
`default_nettype none

module host_bridge_model (
  input wire logic clock, // Bus clock
  output logic cfg_read, // Read strobe
  output logic cfg_write, // Write strobe
  output logic [5:0] cfg_dword, // Dword index
  output logic [3:0] cfg_byte_en, // Byte enables
  output logic [31:0] cfg_wdata, // Write data
  output logic addr_parity_err, // Address parity error pulse
  output logic data_parity_err, // Data parity error pulse
  output logic io_access, // I/O cycle pulse
  output logic [3:0] io_byte_en, // I/O byte enables
  input wire logic [31:0] cfg_rdata, // Read data
  input wire logic cfg_done, // Completion pulse
  input wire logic perr_pulse, // Parity-error request
  input wire logic serr_pulse, // System-error request
  input wire logic io_target_abort // Abort request
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cfg_read = 1'b0;
    cfg_write = 1'b0;
    cfg_dword = 6'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0000_0000;
    addr_parity_err = 1'b0;
    data_parity_err = 1'b0;
    io_access = 1'b0;
    io_byte_en = 4'h0;
  end

  // ****************************************************************
  // Configuration cycle, held one edge, answer taken one cycle later
  // ****************************************************************
  task automatic cfg_access(input logic wr, input logic [5:0] dword, input logic [3:0] be,
                            input logic [31:0] wdata, output logic done, output logic [31:0] rdata);
    @(posedge clock);
    cfg_read <= ~wr;
    cfg_write <= wr;
    cfg_dword <= dword;
    cfg_byte_en <= be;
    cfg_wdata <= wdata;
    @(posedge clock);
    cfg_read <= 1'b0;
    cfg_write <= 1'b0;
    // Released lines must not keep the last value
    cfg_dword <= ~dword;
    cfg_byte_en <= ~be;
    cfg_wdata <= ~wdata;
    #1;
    done = cfg_done;
    rdata = cfg_rdata;
  endtask : cfg_access

  // ****************************************************************
  // Event pulse; kind bit 0 address parity, bit 1 data parity, bit 2 I/O
  // ****************************************************************
  task automatic bus_event(input logic [2:0] kind, input logic [3:0] be, output logic [2:0] seen);
    @(posedge clock);
    addr_parity_err <= kind[0];
    data_parity_err <= kind[1];
    io_access <= kind[2];
    io_byte_en <= be;
    @(posedge clock);
    addr_parity_err <= 1'b0;
    data_parity_err <= 1'b0;
    io_access <= 1'b0;
    io_byte_en <= ~be;
    #1;
    seen = {io_target_abort, serr_pulse, perr_pulse};
  endtask : bus_event

endmodule : host_bridge_model

`default_nettype wire

/* tb_top.sv */
// Self-checking testbench of the configuration register bank
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] VEN = 16'h1234; // Arbitrary value
  localparam logic [15:0] DEV = 16'h5678; // Arbitrary value
  localparam logic [7:0] REV = 8'h01; // Arbitrary value

  logic clock, resetn, ce, cfg_read, cfg_write, addr_parity_err, data_parity_err, io_access;
  logic [5:0] cfg_dword;
  logic [3:0] cfg_byte_en, io_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic cfg_done, perr_pulse, serr_pulse, io_target_abort, io_decode_en, mem_decode_en;
  logic palette_read_claim, rom_decode_en;
  logic [7:0] mem_window_base;
  logic [13:0] rom_base;
  logic done;
  logic [31:0] rd;
  int fails, checked;

  logic [15:0] p_cmd [7] = '{16'h0000, 16'h0040, 16'h0100, 16'h0140, 16'h0040, 16'h0140, 16'h0000};
  logic [2:0] p_kind [7] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2};
  logic [2:0] p_puls [7] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h1, 3'h1, 3'h0};
  logic [15:0] p_stat [7] = '{16'h8280, 16'h8280, 16'h8280, 16'hc280, 16'h8280, 16'h8280, 16'h8280};

  host_bridge_model host (.clock(clock), .cfg_read(cfg_read), .cfg_write(cfg_write), .cfg_dword(cfg_dword),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .addr_parity_err(addr_parity_err),
    .data_parity_err(data_parity_err), .io_access(io_access), .io_byte_en(io_byte_en),
    .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .perr_pulse(perr_pulse), .serr_pulse(serr_pulse),
    .io_target_abort(io_target_abort));

  pci_target_config_space #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .REVISION_CODE(REV)) dut (
    .clock(clock), .resetn(resetn), .ce(ce), .cfg_read(cfg_read), .cfg_write(cfg_write),
    .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .addr_parity_err(addr_parity_err), .data_parity_err(data_parity_err), .io_access(io_access),
    .io_byte_en(io_byte_en), .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .perr_pulse(perr_pulse),
    .serr_pulse(serr_pulse), .io_target_abort(io_target_abort), .io_decode_en(io_decode_en),
    .mem_decode_en(mem_decode_en), .palette_read_claim(palette_read_claim),
    .rom_decode_en(rom_decode_en), .mem_window_base(mem_window_base), .rom_base(rom_base));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] v);
    host.cfg_access(1'b1, dw, be, v, done, rd);
    check({31'h0, done}, 32'h1);
  endtask : wr

  task automatic rd_chk(input logic [5:0] dw, input logic [31:0] exp);
    host.cfg_access(1'b0, dw, 4'hf, 32'h0, done, rd);
    check({31'h0, done}, 32'h1);
    check(rd, exp);
  endtask : rd_chk

  task automatic ev_chk(input logic [2:0] kind, input logic [3:0] be, input logic [2:0] exp);
    logic [2:0] s;
    host.bus_event(kind, be, s);
    check({29'h0, s}, {29'h0, exp});
  endtask : ev_chk

  // Expected contents of the fixed and reserved dwords after reset
  function automatic logic [31:0] fixed_val(input int i);
    case (i)
      0: return {DEV, VEN};
      1: return 32'h0280_0080;
      2: return {8'h03, 8'h00, 8'h00, REV};
      default: return 32'h0000_0000;
    endcase
  endfunction : fixed_val

  // Own reading of a gap between active lanes
  function automatic logic lane_gap(input logic [3:0] be);
    int first, last, n;
    first = -1;
    last = 0;
    n = 0;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        if (first < 0) first = k;
        last = k;
        n++;
      end
    end
    return (n > 0) && (n != last - first + 1);
  endfunction : lane_gap

  task automatic report_and_stop();
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge clock);
    check({24'h0, io_decode_en, mem_decode_en, palette_read_claim, rom_decode_en, cfg_done, perr_pulse,
           serr_pulse, io_target_abort}, 32'h20);
    resetn <= 1'b1;
    // ****************************************************************
    // Reset contents, fixed and reserved places ignore writes
    // ****************************************************************
    for (int i = 0; i < 16; i++) rd_chk(6'(i), fixed_val(i));
    for (int i = 0; i < 16; i++) begin
      if (i != 1 && i != 4 && i != 12) wr(6'(i), 4'hf, 32'hffff_ffff);
    end
    for (int i = 0; i < 16; i++) rd_chk(6'(i), fixed_val(i));
    rd_chk(6'h3f, 32'h0000_0000);
    // ****************************************************************
    // Command bits and byte lanes
    // ****************************************************************
    wr(6'h01, 4'h3, 32'hffff_ffff);
    rd_chk(6'h01, 32'h0280_01e3);
    check({29'h0, io_decode_en, mem_decode_en, palette_read_claim}, 32'h6);
    wr(6'h01, 4'h2, 32'h0000_0000);
    rd_chk(6'h01, 32'h0280_00e3);
    wr(6'h01, 4'h1, 32'h0000_0000);
    rd_chk(6'h01, 32'h0280_0080);
    check({29'h0, io_decode_en, mem_decode_en, palette_read_claim}, 32'h1);
    // Clock enable low: request is not taken
    @(posedge clock);
    ce <= 1'b0;
    host.cfg_access(1'b1, 6'h01, 4'h3, 32'h0000_ffff, done, rd);
    check({31'h0, done}, 32'h0);
    @(posedge clock);
    ce <= 1'b1;
    rd_chk(6'h01, 32'h0280_0080);
    // ****************************************************************
    // Base address registers
    // ****************************************************************
    wr(6'h04, 4'h7, 32'hffff_ffff);
    rd_chk(6'h04, 32'h0000_0000);
    wr(6'h04, 4'h8, 32'ha5ff_ffff);
    rd_chk(6'h04, 32'ha500_0000);
    check({24'h0, mem_window_base}, 32'ha5);
    wr(6'h0c, 4'hf, 32'hffff_ffff);
    rd_chk(6'h0c, 32'hfffc_0001);
    check({17'h0, rom_base, rom_decode_en}, {17'h0, 14'h3fff, 1'b0});
    wr(6'h01, 4'h1, 32'h0000_0002);
    check({30'h0, mem_decode_en, rom_decode_en}, 32'h3);
    // ****************************************************************
    // Parity errors against the enable settings
    // ****************************************************************
    for (int i = 0; i < 7; i++) begin
      wr(6'h01, 4'hc, 32'hffff_0000);
      wr(6'h01, 4'h3, {16'h0, p_cmd[i]});
      ev_chk(p_kind[i], 4'h0, p_puls[i]);
      rd_chk(6'h01, {p_stat[i], p_cmd[i] | 16'h0080});
    end
    wr(6'h01, 4'h3, 32'h0000_0140);
    ev_chk(3'h1, 4'h0, 3'h3);
    wr(6'h01, 4'hb, 32'h4000_0000);
    rd_chk(6'h01, 32'h8280_0080);
    wr(6'h01, 4'hc, 32'h0000_0000);
    rd_chk(6'h01, 32'h8280_0080);
    wr(6'h01, 4'hc, 32'hffff_0000);
    rd_chk(6'h01, 32'h0280_0080);
    // ****************************************************************
    // I/O byte-enable patterns and target abort
    // ****************************************************************
    wr(6'h01, 4'h3, 32'h0000_0000);
    ev_chk(3'h4, 4'h5, 3'h0);
    rd_chk(6'h01, 32'h0280_0080);
    wr(6'h01, 4'h3, 32'h0000_0001);
    for (int b = 0; b < 16; b++) ev_chk(3'h4, 4'(b), {lane_gap(4'(b)), 2'b00});
    rd_chk(6'h01, 32'h0a80_0081);
    wr(6'h01, 4'hc, 32'h0800_0000);
    rd_chk(6'h01, 32'h0280_0081);
    // ****************************************************************
    // Second reset returns enables to zero
    // ****************************************************************
    wr(6'h01, 4'h3, 32'h0000_0163);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    rd_chk(6'h01, 32'h0280_0080);
    rd_chk(6'h04, 32'h0000_0000);
    report_and_stop();
  end

endmodule : tb_top

`default_nettype wire
